// ===== include/host_cmd_regs.vh
// Constants for the host command block: register map, command codes,
// reply codes, pin configuration fields and timing figures.
// Assumes a 10 MHz system clock and byte addresses on the register port.
`ifndef HOST_CMD_REGS_VH
`define HOST_CMD_REGS_VH

// Register byte addresses
`define REG_CMD        8'h00
`define REG_DATA       8'h04
`define REG_EXEC       8'h08
`define REG_REPLY      8'h0c
`define REG_STATE      8'h10
`define REG_PIN_BASE   8'h20
`define REG_RDATA_BASE 8'h40
`define REG_WIN_SPAN   8'h20

// Field layout in the command register and the reply valid bit in the reply register
`define CMD_TYPE_MSB   7
`define CMD_LEN_LSB    8
`define CMD_LEN_MSB    12
`define REPLY_VLD_BIT  16

// Command and reply types
`define T_WATCHDOG     8'h1d
`define T_STATUS       8'h1e
`define T_LCD_WRITE    8'h1f
`define T_BAUD         8'h21
`define T_GPIO         8'h22
`define T_ACK_BIT      8'h40
`define T_NAK_BITS     8'hc0

// Payload limits
`define LEN_W          5
`define STAT_LEN       5'h0f
`define STAT_WD_BYTE   4'h8
`define LCD_LEN_MIN    5'h03
`define LCD_LEN_MAX    5'h12
`define LCD_COL_MAX    8'h0f
`define LCD_ROW_MAX    8'h01
`define LCD_TEXT_OFS   5'h02
`define BAUD_MAX       8'h01
`define BAUD_19200     1'b0
`define GPIO_COUNT     5
`define GPIO_LEN_VAL   5'h02
`define GPIO_LEN_CFG   5'h03
`define GPIO_VAL_HIGH  8'h64
`define GPIO_CFG_MAX   8'h0f
`define GPIO_RST_PIN   3
`define GPIO_BUS_PIN   4

// Drive mode field codes
`define DM_SUP_RDN     3'h0
`define DM_SUP_SDN     3'h1
`define DM_HIZ         3'h2
`define DM_RUP_SDN     3'h3
`define DM_SLUP_HIZ    3'h4
`define DM_SLUP_SLDN   3'h5
`define DM_RSVD        3'h6
`define DM_HIZ_SLDN    3'h7
`define CFG_FUNC_BIT   3

// Timing
`define CLK_HZ         10000000
`define WD_TICK_HZ     1
`define SAMPLE_HZ      32
`define PWM_HZ         100
`define PWM_STEPS      7'h64
`define RST_PULSE_MS   1000
`define CNT_W          24

`endif

// ===== hdl/gpio_pin_ctl.v
// One general-purpose pin: value, function and drive mode settings,
// duty-cycle output, pad drive decode and sampled input with edge flags.
// Assumes the pin input comes from the pad, outside the clock domain.
`timescale 1ns/1ps
`include "host_cmd_regs.vh"
module gpio_pin_ctl #(
   parameter [3:0] RST_CFG = {1'b0, `DM_HIZ}
)(
   input wire mclk,
   input wire rst,
   input wire ce,
   input wire tick32,
   input wire [6:0] pwm_phase,
   input wire wr_val,
   input wire wr_cfg,
   input wire [7:0] val_in,
   input wire [3:0] cfg_in,
   input wire query,
   input wire dflt_o,
   input wire dflt_oe,
   input wire pin_i,
   output reg pin_o,
   output reg pin_oe,
   output reg pin_pu,
   output reg pin_pd,
   output reg pin_slow,
   output wire [7:0] val,
   output wire [3:0] cfg,
   output wire [2:0] sts
);
   reg [7:0] val_ff;
   reg [3:0] cfg_ff;
   reg sync1_ff, sync2_ff, smp_ff, primed_ff, rise_ff, fall_ff;
   reg lvl, nxt_o, nxt_oe, nxt_pu, nxt_pd, nxt_slow;
   wire func = cfg_ff[`CFG_FUNC_BIT];
   wire rise_evt = tick32 & primed_ff & sync2_ff & ~smp_ff;
   wire fall_evt = tick32 & primed_ff & ~sync2_ff & smp_ff;

   assign val = val_ff;
   assign cfg = cfg_ff;
   assign sts = {rise_ff, fall_ff, smp_ff};

   // Settings, input sampling and edge memory
   always @(posedge mclk) begin
      if (rst) begin
         val_ff <= 8'h00;
         cfg_ff <= RST_CFG;
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         smp_ff <= 1'b0;
         primed_ff <= 1'b0;
         rise_ff <= 1'b0;
         fall_ff <= 1'b0;
      end else if (ce) begin
         if (wr_val)
            val_ff <= val_in; // RULE_15
         if (wr_cfg)
            cfg_ff <= cfg_in; // RULE_15
         sync1_ff <= pin_i;
         sync2_ff <= sync1_ff;
         if (tick32) begin
            smp_ff <= sync2_ff; // RULE_20
            primed_ff <= 1'b1;
         end
         // New edge wins over a query clear in the same cycle
         rise_ff <= (rise_ff & ~query) | rise_evt; // RULE_21
         fall_ff <= (fall_ff & ~query) | fall_evt; // RULE_21
      end
   end

   // Output level and pad drive decode
   always @* begin
      if (val_ff == 8'h00)
         lvl = 1'b0;
      else if (val_ff >= `GPIO_VAL_HIGH)
         lvl = 1'b1;
      else
         lvl = ({1'b0, pwm_phase} < val_ff); // RULE_16
      nxt_o = lvl;
      nxt_oe = 1'b0;
      nxt_pu = 1'b0;
      nxt_pd = 1'b0;
      nxt_slow = 1'b0;
      case (cfg_ff[2:0]) // RULE_17
         `DM_SUP_RDN: begin
            nxt_oe = lvl;
            nxt_pd = ~lvl;
         end
         `DM_SUP_SDN: nxt_oe = 1'b1;
         `DM_RUP_SDN: begin
            nxt_oe = ~lvl;
            nxt_pu = lvl;
         end
         `DM_SLUP_HIZ: begin
            nxt_oe = lvl;
            nxt_slow = 1'b1;
         end
         `DM_SLUP_SLDN: begin
            nxt_oe = 1'b1;
            nxt_slow = 1'b1;
         end
         `DM_HIZ_SLDN: begin
            nxt_oe = ~lvl;
            nxt_slow = 1'b1;
         end
         default: nxt_oe = 1'b0;
      endcase
      // Default function owns the pad; only the DM_RUP_SDN pull-up stays, while the pad is undriven
      if (!func) begin
         nxt_o = dflt_o; // RULE_18
         nxt_oe = dflt_oe; // RULE_18
         nxt_pd = 1'b0;
         nxt_slow = 1'b0;
         nxt_pu = (cfg_ff[2:0] == `DM_RUP_SDN) & ~dflt_oe;
      end
   end

   // Registered pad controls
   always @(posedge mclk) begin
      if (rst) begin
         pin_o <= 1'b0;
         pin_oe <= 1'b0;
         pin_pu <= 1'b0;
         pin_pd <= 1'b0;
         pin_slow <= 1'b0;
      end else if (ce) begin
         pin_o <= nxt_o;
         pin_oe <= nxt_oe;
         pin_pu <= nxt_pu;
         pin_pd <= nxt_pd;
         pin_slow <= nxt_slow;
      end
   end
endmodule

// ===== hdl/host_cmd_watchdog_gpio_baud.v
// Host command handler: watchdog, status readback, display writes,
// serial rate switching and general-purpose pin configuration.
// Assumes a register port master on mclk and a serial engine that reads
// the reply register when it sends the reply packet.
//
// How it works
// RULE_01 - A watchdog timeout of zero turns the watchdog off, even mid-count.
// RULE_02 - Host must resend the watchdog command before the timeout runs out.
// RULE_03 - An expired, still enabled watchdog pulses the host reset output.
// RULE_04 - Watchdog is off after reset and stays off after firing.
// RULE_05 - Accepted commands reply with type OR 0x40; only the status reply carries a payload.
// RULE_06 - Status query without payload returns fifteen status bytes.
// RULE_07 - Status byte 8 holds the present watchdog counter.
// RULE_08 - Display write gives column, row, then 1 to 16 characters placed there.
// RULE_09 - Host keeps display write length between 3 and 18 bytes.
// RULE_10 - Serial rate changes only after the acknowledge went out at the old rate.
// RULE_11 - Host waits for the acknowledge before changing its own rate.
// RULE_12 - Rate byte 0 selects 19200 baud, 1 selects 115200 baud.
// RULE_13 - Serial rate after reset is 19200 baud.
// RULE_14 - Five pins, index 0 to 4; larger indices are refused.
// RULE_15 - Two payload bytes set the value; three also set function and mode.
// RULE_16 - Value 0 low, 1-99 duty percent at 100 Hz, 100 high, above invalid.
// RULE_17 - Three-bit drive mode selects pad drive; code 110 is refused.
// RULE_18 - Function bit 0 gives the pin its default function, 1 user control.
// RULE_19 - Host keeps the configuration byte within 0 to 15.
// RULE_20 - All pins are sampled at 32 Hz regardless of queries.
// RULE_21 - Rising and falling edges since the last query are remembered.
// RULE_22 - Host leaves the reset pin in its default function and mode.
// RULE_23 - Host reset pin floats except while a reset pulse drives it.
// RULE_24 - Counter reloads on each watchdog command, counts seconds, fires at zero.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "host_cmd_regs.vh"
module host_cmd_watchdog_gpio_baud #(
   parameter SEC_CYCLES = `CLK_HZ / `WD_TICK_HZ,
   parameter SAMPLE_CYCLES = `CLK_HZ / `SAMPLE_HZ,
   parameter RST_PULSE_CYCLES = (`CLK_HZ / 1000) * `RST_PULSE_MS,
   parameter NPIN = `GPIO_COUNT
)(
   input wire mclk,
   input wire rst,
   input wire ce,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata,
   input wire [119:0] stat_bytes,
   input wire reset_invert,
   input wire sensor_bus_port_o,
   input wire sensor_bus_port_oe,
   output reg baud_sel,
   output reg lcd_we,
   output reg [4:0] lcd_addr,
   output reg [7:0] lcd_char,
   input wire [NPIN-1:0] gpio_i,
   output wire [NPIN-1:0] gpio_o,
   output wire [NPIN-1:0] gpio_oe,
   output wire [NPIN-1:0] gpio_pu,
   output wire [NPIN-1:0] gpio_pd,
   output wire [NPIN-1:0] gpio_slow
);
   localparam [`CNT_W-1:0] SEC_LAST = SEC_CYCLES - 1;
   localparam [`CNT_W-1:0] SMP_LAST = SAMPLE_CYCLES - 1;
   localparam [`CNT_W-1:0] PULSE_LAST = RST_PULSE_CYCLES - 1;
   localparam [`CNT_W-1:0] PWM_LAST = `CLK_HZ / (`PWM_HZ * `PWM_STEPS) - 1;
   localparam [6:0] PHASE_LAST = `PWM_STEPS - 7'h01;

   reg [7:0] type_ff;
   reg [`LEN_W-1:0] len_ff, cnt_ff;
   reg [7:0] p0_ff, p1_ff, p2_ff;
   reg [7:0] rtype_ff, stat_wd_ff;
   reg [`LEN_W-1:0] rlen_ff;
   reg rvld_ff, baud_pend_ff, baud_new_ff;
   reg wd_en_ff, pulse_ff;
   reg [7:0] wd_cnt_ff;
   reg [`CNT_W-1:0] sec_ff, smp_ff, pwm_ff, pulse_cnt_ff;
   reg [6:0] phase_ff;
   reg tick32_ff;
   reg ok;
   reg [31:0] nxt_rdata;

   wire wr_cmd = wr & (addr == `REG_CMD);
   wire wr_dat = wr & (addr == `REG_DATA);
   wire exec = wr & (addr == `REG_EXEC);
   wire rd_reply = rd & (addr == `REG_REPLY);
   wire sec_tick = (sec_ff == SEC_LAST);
   wire pwm_step = (pwm_ff == PWM_LAST);
   wire [7:0] pin_off = addr - `REG_PIN_BASE;
   wire [7:0] rd_off = addr - `REG_RDATA_BASE;
   wire in_pin = (addr >= `REG_PIN_BASE) && (pin_off < `REG_WIN_SPAN);
   wire in_rdt = (addr >= `REG_RDATA_BASE) && (rd_off[7:6] == 2'b00);
   wire [2:0] pin_sel = pin_off[4:2];
   wire [3:0] byte_sel = rd_off[5:2];
   wire pin_hit = in_pin && (pin_sel < NPIN) && (addr[1:0] == 2'b00);
   wire wd_cmd = exec & ok & (type_ff == `T_WATCHDOG);
   wire gpio_cmd = exec & ok & (type_ff == `T_GPIO);
   wire lcd_ok = (type_ff == `T_LCD_WRITE) && (len_ff >= `LCD_LEN_MIN) &&
                 (len_ff <= `LCD_LEN_MAX);
   wire [`LEN_W-1:0] text_n = cnt_ff - `LCD_TEXT_OFS;
   wire [7:0] text_col = p0_ff + {3'b000, text_n};

   // Command acceptance check
   always @* begin
      ok = 1'b0;
      case (type_ff)
         `T_WATCHDOG: ok = (len_ff == 5'h01);
         `T_STATUS: ok = (len_ff == 5'h00); // RULE_06
         `T_LCD_WRITE: ok = lcd_ok && (p0_ff <= `LCD_COL_MAX) &&
                            (p1_ff <= `LCD_ROW_MAX); // RULE_08
         `T_BAUD: ok = (len_ff == 5'h01) && (p0_ff <= `BAUD_MAX); // RULE_12
         `T_GPIO: ok = ((len_ff == `GPIO_LEN_VAL) || (len_ff == `GPIO_LEN_CFG)) &&
                       (p0_ff < NPIN) && (p1_ff <= `GPIO_VAL_HIGH) && // RULE_14
                       ((len_ff == `GPIO_LEN_VAL) || ((p2_ff <= `GPIO_CFG_MAX) &&
                       (p2_ff[2:0] != `DM_RSVD))); // RULE_17
         default: ok = 1'b0;
      endcase
      if (cnt_ff != len_ff)
         ok = 1'b0;
   end

   // Command capture, payload bytes and display text stream
   always @(posedge mclk) begin
      if (rst) begin
         type_ff <= 8'h00;
         len_ff <= {`LEN_W{1'b0}};
         cnt_ff <= {`LEN_W{1'b0}};
         p0_ff <= 8'h00;
         p1_ff <= 8'h00;
         p2_ff <= 8'h00;
         lcd_we <= 1'b0;
         lcd_addr <= 5'h00;
         lcd_char <= 8'h00;
      end else if (ce) begin
         lcd_we <= 1'b0;
         if (wr_cmd) begin
            type_ff <= wdata[`CMD_TYPE_MSB:0];
            len_ff <= wdata[`CMD_LEN_MSB:`CMD_LEN_LSB];
            cnt_ff <= {`LEN_W{1'b0}};
         end else if (wr_dat && (cnt_ff < len_ff)) begin
            cnt_ff <= cnt_ff + 5'h01;
            if (cnt_ff == 5'h00)
               p0_ff <= wdata[7:0];
            if (cnt_ff == 5'h01)
               p1_ff <= wdata[7:0];
            if (cnt_ff == 5'h02)
               p2_ff <= wdata[7:0];
            // Text lands from the given column onward, cut at the line end
            if (lcd_ok && (cnt_ff >= `LCD_TEXT_OFS) && (p1_ff <= `LCD_ROW_MAX) &&
                (text_col <= `LCD_COL_MAX)) begin
               lcd_we <= 1'b1; // RULE_08
               lcd_addr <= {p1_ff[0], text_col[3:0]};
               lcd_char <= wdata[7:0];
            end
         end
      end
   end

   // Reply register and deferred rate switch
   always @(posedge mclk) begin
      if (rst) begin
         rtype_ff <= 8'h00;
         rlen_ff <= {`LEN_W{1'b0}};
         rvld_ff <= 1'b0;
         stat_wd_ff <= 8'h00;
         baud_pend_ff <= 1'b0;
         baud_new_ff <= `BAUD_19200;
         baud_sel <= `BAUD_19200; // RULE_13
      end else if (ce) begin
         if (exec) begin
            rvld_ff <= 1'b1;
            rtype_ff <= ok ? (type_ff | `T_ACK_BIT) : (type_ff | `T_NAK_BITS); // RULE_05
            rlen_ff <= (ok && (type_ff == `T_STATUS)) ? `STAT_LEN : 5'h00; // RULE_06
            stat_wd_ff <= wd_cnt_ff; // RULE_07
            if (ok && (type_ff == `T_BAUD)) begin
               baud_pend_ff <= 1'b1;
               baud_new_ff <= p0_ff[0]; // RULE_12
            end
         end else if (rd_reply) begin
            rvld_ff <= 1'b0;
            // The acknowledge is taken at the old rate, then the rate moves
            if (baud_pend_ff) begin
               baud_sel <= baud_new_ff; // RULE_10
               baud_pend_ff <= 1'b0;
            end
         end
      end
   end

   // Second, sample and duty-cycle time bases
   always @(posedge mclk) begin
      if (rst) begin
         sec_ff <= {`CNT_W{1'b0}};
         smp_ff <= {`CNT_W{1'b0}};
         pwm_ff <= {`CNT_W{1'b0}};
         phase_ff <= 7'h00;
         tick32_ff <= 1'b0;
      end else if (ce) begin
         sec_ff <= sec_tick ? {`CNT_W{1'b0}} : sec_ff + 1'b1;
         tick32_ff <= (smp_ff == SMP_LAST); // RULE_20
         smp_ff <= (smp_ff == SMP_LAST) ? {`CNT_W{1'b0}} : smp_ff + 1'b1;
         pwm_ff <= pwm_step ? {`CNT_W{1'b0}} : pwm_ff + 1'b1;
         if (pwm_step)
            phase_ff <= (phase_ff == PHASE_LAST) ? 7'h00 : phase_ff + 7'h01; // RULE_16
      end
   end

   // Watchdog counter and host reset pulse
   always @(posedge mclk) begin
      if (rst) begin
         wd_en_ff <= 1'b0; // RULE_04
         wd_cnt_ff <= 8'h00;
         pulse_ff <= 1'b0;
         pulse_cnt_ff <= {`CNT_W{1'b0}};
      end else if (ce) begin
         if (wd_cmd) begin
            wd_cnt_ff <= p0_ff; // RULE_24
            wd_en_ff <= (p0_ff != 8'h00); // RULE_01
         end else if (wd_en_ff && sec_tick) begin
            wd_cnt_ff <= wd_cnt_ff - 8'h01; // RULE_24
            if (wd_cnt_ff == 8'h01) begin
               wd_en_ff <= 1'b0; // RULE_04
               pulse_ff <= 1'b1; // RULE_03
               pulse_cnt_ff <= {`CNT_W{1'b0}};
            end
         end
         if (pulse_ff) begin
            pulse_cnt_ff <= pulse_cnt_ff + 1'b1;
            if (pulse_cnt_ff == PULSE_LAST)
               pulse_ff <= 1'b0; // RULE_23
         end
      end
   end

   // Default-function drive for each pin
   wire [NPIN-1:0] dflt_o, dflt_oe, wr_val, wr_cfg, query;
   wire [NPIN*8-1:0] pin_val;
   wire [NPIN*4-1:0] pin_cfg;
   wire [NPIN*3-1:0] pin_sts;

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
         if (gi == `GPIO_RST_PIN) begin : g_rst
            assign dflt_o[gi] = reset_invert; // RULE_23
            assign dflt_oe[gi] = pulse_ff; // RULE_03
         end else if (gi == `GPIO_BUS_PIN) begin : g_bus
            assign dflt_o[gi] = sensor_bus_port_o;
            assign dflt_oe[gi] = sensor_bus_port_oe;
         end else begin : g_idle
            assign dflt_o[gi] = 1'b0;
            assign dflt_oe[gi] = 1'b0;
         end
         assign wr_val[gi] = gpio_cmd & (p0_ff == gi); // RULE_15
         assign wr_cfg[gi] = wr_val[gi] & (len_ff == `GPIO_LEN_CFG); // RULE_15
         assign query[gi] = rd & pin_hit & (pin_sel == gi); // RULE_21
         gpio_pin_ctl #(
            .RST_CFG((gi == 1) ? {1'b0, `DM_RUP_SDN} : {1'b0, `DM_HIZ})
         ) u_pin (
            .mclk(mclk),
            .rst(rst),
            .ce(ce),
            .tick32(tick32_ff),
            .pwm_phase(phase_ff),
            .wr_val(wr_val[gi]),
            .wr_cfg(wr_cfg[gi]),
            .val_in(p1_ff),
            .cfg_in(p2_ff[3:0]),
            .query(query[gi]),
            .dflt_o(dflt_o[gi]),
            .dflt_oe(dflt_oe[gi]),
            .pin_i(gpio_i[gi]),
            .pin_o(gpio_o[gi]),
            .pin_oe(gpio_oe[gi]),
            .pin_pu(gpio_pu[gi]),
            .pin_pd(gpio_pd[gi]),
            .pin_slow(gpio_slow[gi]),
            .val(pin_val[gi*8 +: 8]),
            .cfg(pin_cfg[gi*4 +: 4]),
            .sts(pin_sts[gi*3 +: 3])
         );
      end
   endgenerate

   // Read data selection
   always @* begin
      nxt_rdata = 32'h0000_0000;
      if (rd) begin
         if (addr == `REG_CMD)
            nxt_rdata = {19'h0, len_ff, type_ff};
         else if (addr == `REG_REPLY)
            nxt_rdata = {15'h0, rvld_ff, 3'h0, rlen_ff, rtype_ff};
         else if (addr == `REG_STATE)
            nxt_rdata = {20'h0, wd_cnt_ff, pulse_ff, baud_pend_ff, baud_sel, wd_en_ff};
         else if (pin_hit)
            nxt_rdata = {12'h0, pin_cfg[pin_sel*4 +: 4], pin_val[pin_sel*8 +: 8],
                         5'h00, pin_sts[pin_sel*3 +: 3]}; // RULE_21
         else if (in_rdt && (addr[1:0] == 2'b00) && (byte_sel < `STAT_LEN)) begin
            if (byte_sel == `STAT_WD_BYTE)
               nxt_rdata = {24'h0, stat_wd_ff}; // RULE_07
            else
               nxt_rdata = {24'h0, stat_bytes[byte_sel*8 +: 8]}; // RULE_06
         end
      end
   end

   // Read data stand for one cycle only
   always @(posedge mclk) begin
      if (rst)
         rdata <= 32'h0000_0000;
      else if (ce)
         rdata <= nxt_rdata;
   end
endmodule

// ===== sim/host_cmd_checker_assertions.sv
// Checker for the host command block: read answers, rate switch,
// display strobes and the host reset pulse.
// Assumes it is bound to the block's top module with its pulse length.
`timescale 1ns/1ps
module host_cmd_checker #(
   parameter RST_PULSE_CYCLES = 5,
   parameter NPIN = 5
)(
   input wire mclk,
   input wire rst,
   input wire ce,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   input wire [31:0] rdata,
   input wire reset_invert,
   input wire baud_sel,
   input wire lcd_we,
   input wire [7:0] lcd_char,
   input wire [NPIN-1:0] gpio_o,
   input wire [NPIN-1:0] gpio_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Read data only in the cycle after a read strobe
   rdata_idle_a: assert property ((!$past(rd) && $past(ce)) |-> rdata == 32'h0)
      else $error("read data outside its cycle");
   // Rate moves only after the reply was fetched
   baud_hold_a: assert property ($changed(baud_sel) |-> $past(rd) && $past(addr) == 8'h0c)
      else $error("serial rate changed before the reply went out");
   // Each character comes from a payload write
   lcd_source_a: assert property (lcd_we |-> $past(wr) && $past(addr) == 8'h04)
      else $error("character strobe without payload write");
   lcd_char_a: assert property (lcd_we |-> lcd_char == $past(wdata[7:0]))
      else $error("character differs from payload byte");
   // Reset pulse has a fixed length then floats again
   pulse_len_a: assert property ($rose(gpio_oe[3]) |-> gpio_oe[3] [*5] ##1 !gpio_oe[3])
      else $error("host reset pulse length wrong");
   pulse_level_a: assert property (gpio_oe[3] |-> gpio_o[3] == reset_invert)
      else $error("host reset pulse at wrong level");
   // No reset pulse right after power-up
   quiet_boot_a: assert property ($fell(rst) |-> (!gpio_oe[3]) [*8])
      else $error("host reset pulse after power-up");
   // Reserved pin index reads as zero
   pin_rsvd_a: assert property ($past(rd) && $past(addr) == 8'h34 |-> rdata == 32'h0)
      else $error("reserved pin index answered");
endmodule

bind host_cmd_watchdog_gpio_baud host_cmd_checker #(
   .RST_PULSE_CYCLES(RST_PULSE_CYCLES),
   .NPIN(NPIN)
) chk_u (
   .mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .reset_invert(reset_invert), .baud_sel(baud_sel), .lcd_we(lcd_we),
   .lcd_char(lcd_char), .gpio_o(gpio_o), .gpio_oe(gpio_oe)
);

// ===== sim/gpio_pad_model.sv
// Pad model: resolves each pin from the block's drive, its weak pulls
// and an external driver owned by the bench.
// Assumes a floating pin must not look stable, so it flips each cycle.
`timescale 1ns/1ps
module gpio_pad_model #(
   parameter NPIN = 5
)(
   input wire mclk,
   input wire [NPIN-1:0] pin_o,
   input wire [NPIN-1:0] pin_oe,
   input wire [NPIN-1:0] pin_pu,
   input wire [NPIN-1:0] pin_pd,
   input wire [NPIN-1:0] ext_en,
   input wire [NPIN-1:0] ext_val,
   output reg [NPIN-1:0] pin_i
);
   reg [NPIN-1:0] last_ff = 0;
   integer i;
   // External drive wins, then block drive, then pulls
   always @* begin
      for (i = 0; i < NPIN; i = i + 1) begin
         if (ext_en[i]) pin_i[i] = ext_val[i];
         else if (pin_oe[i]) pin_i[i] = pin_o[i];
         else if (pin_pu[i]) pin_i[i] = 1'b1;
         else if (pin_pd[i]) pin_i[i] = 1'b0;
         else pin_i[i] = ~last_ff[i];
      end
   end
   // Memory of the last level for the floating case
   always @(posedge mclk) last_ff <= pin_i;
endmodule

// ===== sim/host_cmd_watchdog_gpio_baud_tb.sv
// Bench for the host command block: register tasks, command runs and
// watchdog, display, rate and pin checks.
// Assumes shortened second, sample and pulse counts set below.
`timescale 1ns/1ps
module host_cmd_watchdog_gpio_baud_tb;
   reg mclk = 0, rst = 1, wr = 0, rd = 0, reset_invert = 1, pre_baud, oe3_q = 0, ce = 1;
   reg [7:0] addr = 0;
   reg [31:0] wdata = 0, r;
   reg [4:0] ext_en = 0, ext_val = 0;
   reg [119:0] sb = 0;
   reg [7:0] pl [0:17];
   reg [12:0] lq [0:7];
   wire [31:0] rdata;
   wire baud_sel, lcd_we;
   wire [4:0] lcd_addr, gpio_i, gpio_o, gpio_oe, gpio_pu, gpio_pd;
   wire [7:0] lcd_char;
   integer error_cnt = 0, check_count = 0, pulses = 0, bad_lvl = 0, ln = 0, m;
   localparam [7:0] oe_hi = 8'h33;
   localparam [7:0] oe_lo = 8'haa;

   host_cmd_watchdog_gpio_baud #(.SEC_CYCLES(20), .SAMPLE_CYCLES(8),
      .RST_PULSE_CYCLES(5)) DUT (
      .mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .stat_bytes(sb), .reset_invert(reset_invert),
      .sensor_bus_port_o(1'b0), .sensor_bus_port_oe(1'b0), .baud_sel(baud_sel),
      .lcd_we(lcd_we), .lcd_addr(lcd_addr), .lcd_char(lcd_char), .gpio_i(gpio_i),
      .gpio_o(gpio_o), .gpio_oe(gpio_oe), .gpio_pu(gpio_pu), .gpio_pd(gpio_pd),
      .gpio_slow());

   gpio_pad_model pads (.mclk(mclk), .pin_o(gpio_o), .pin_oe(gpio_oe),
      .pin_pu(gpio_pu), .pin_pd(gpio_pd), .ext_en(ext_en), .ext_val(ext_val),
      .pin_i(gpio_i));

   initial forever #50 mclk = ~mclk;

   // Count reset pulses, bad levels and characters
   always @(posedge mclk) begin
      oe3_q <= gpio_oe[3];
      if (gpio_oe[3] === 1'b1 && oe3_q !== 1'b1) pulses <= pulses + 1;
      if (gpio_oe[3] === 1'b1 && gpio_o[3] !== reset_invert) bad_lvl <= bad_lvl + 1;
      if (lcd_we === 1'b1) begin
         lq[ln] <= {lcd_addr, lcd_char};
         ln <= ln + 1;
      end
   end

   task chk(input [31:0] seen, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
         end
      end
   endtask

   task wr_reg(input [7:0] a, input [31:0] d);
      begin
         @(posedge mclk);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge mclk);
         wr <= 1'b0;
      end
   endtask

   task rd_reg(input [7:0] a);
      begin
         @(posedge mclk);
         addr <= a;
         rd <= 1'b1;
         @(posedge mclk);
         rd <= 1'b0;
         #1 r = rdata;
      end
   endtask

   // Send a command, run it and check the reply
   task cmd(input [7:0] t, input [4:0] n, input ok, input [4:0] rl);
      integer i;
      begin
         wr_reg(8'h00, {19'h0, n, t});
         for (i = 0; i < n; i = i + 1) wr_reg(8'h04, {24'h0, pl[i]});
         wr_reg(8'h08, 32'h0);
         pre_baud = baud_sel;
         rd_reg(8'h0c);
         chk(r, {15'h0, 1'b1, 3'h0, ok ? rl : 5'h0, t | (ok ? 8'h40 : 8'hc0)});
      end
   endtask

   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", check_count, error_cnt);
         if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask

   initial begin
      #2000000;
      error_cnt = error_cnt + 1;
      print_verdict;
   end

   initial begin
      for (m = 0; m < 15; m = m + 1) sb[8*m +: 8] = 8'ha0 + m[7:0];
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      rd_reg(8'h10);
      chk(r, 32'h0);
      chk(baud_sel, 1'b0);
      $display("reset test done");
      // Keep the watchdog fed, then let it expire once
      pl[0] = 8'h05;
      for (m = 0; m < 4; m = m + 1) begin
         cmd(8'h1d, 5'h1, 1'b1, 5'h0);
         repeat (50) @(posedge mclk);
      end
      chk(pulses, 0);
      repeat (130) @(posedge mclk);
      chk(pulses, 1);
      chk(bad_lvl, 0);
      repeat (200) @(posedge mclk);
      chk(pulses, 1);
      rd_reg(8'h10);
      chk(r[0], 1'b0);
      pl[0] = 8'h03;
      cmd(8'h1d, 5'h1, 1'b1, 5'h0);
      pl[0] = 8'h00;
      cmd(8'h1d, 5'h1, 1'b1, 5'h0);
      repeat (150) @(posedge mclk);
      chk(pulses, 1);
      $display("watchdog test done");
      // Status readback with a running counter
      pl[0] = 8'hc8;
      cmd(8'h1d, 5'h1, 1'b1, 5'h0);
      cmd(8'h1e, 5'h0, 1'b1, 5'h0f);
      for (m = 0; m < 15; m = m + 1) begin
         rd_reg(8'h40 + {m[5:0], 2'b00});
         if (m != 8) chk(r, {24'h0, 8'ha0 + m[7:0]});
      end
      rd_reg(8'h60);
      chk(r[7:0] >= 8'hc6 && r[7:0] <= 8'hc8, 1'b1);
      cmd(8'h1e, 5'h1, 1'b0, 5'h0);
      pl[0] = 8'h00;
      cmd(8'h1d, 5'h1, 1'b1, 5'h0);
      $display("status test done");
      // Display write running past the last column
      pl[0] = 8'h0e;
      pl[1] = 8'h01;
      pl[2] = 8'h41;
      pl[3] = 8'h42;
      pl[4] = 8'h43;
      cmd(8'h1f, 5'h5, 1'b1, 5'h0);
      chk(ln, 2);
      chk(lq[0], {5'h1e, 8'h41});
      chk(lq[1], {5'h1f, 8'h42});
      pl[0] = 8'h10;
      cmd(8'h1f, 5'h5, 1'b0, 5'h0);
      cmd(8'h1f, 5'h2, 1'b0, 5'h0);
      chk(ln, 2);
      $display("display test done");
      // Rate switch after the reply, bad code refused
      pl[0] = 8'h01;
      cmd(8'h21, 5'h1, 1'b1, 5'h0);
      chk(pre_baud, 1'b0);
      chk(baud_sel, 1'b1);
      pl[0] = 8'h02;
      cmd(8'h21, 5'h1, 1'b0, 5'h0);
      chk(baud_sel, 1'b1);
      pl[0] = 8'h00;
      cmd(8'h21, 5'h1, 1'b1, 5'h0);
      chk(baud_sel, 1'b0);
      $display("rate test done");
      // Every drive mode on a user pin, high then low
      pl[0] = 8'h00;
      for (m = 0; m < 8; m = m + 1) begin
         pl[1] = 8'h64;
         pl[2] = 8'h08 | m[7:0];
         cmd(8'h22, 5'h3, m != 6, 5'h0);
         if (m != 6) chk(gpio_oe[0], oe_hi[m]);
         pl[1] = 8'h00;
         cmd(8'h22, 5'h2, 1'b1, 5'h0);
         if (m != 6) chk(gpio_oe[0], oe_lo[m]);
      end
      rd_reg(8'h20);
      chk(r[19:8], 12'hf00);
      pl[1] = 8'h32;
      cmd(8'h22, 5'h2, 1'b1, 5'h0);
      rd_reg(8'h20);
      chk(r[19:8], 12'hf32);
      pl[0] = 8'h05;
      cmd(8'h22, 5'h2, 1'b0, 5'h0);
      pl[0] = 8'h00;
      pl[1] = 8'h65;
      cmd(8'h22, 5'h2, 1'b0, 5'h0);
      pl[1] = 8'h00;
      pl[2] = 8'h10;
      cmd(8'h22, 5'h3, 1'b0, 5'h0);
      rd_reg(8'h34);
      chk(r, 32'h0);
      $display("pin config test done");
      // Sampled level and edges on an input pin
      pl[2] = 8'h0a;
      cmd(8'h22, 5'h3, 1'b1, 5'h0);
      ext_en <= 5'h01;
      repeat (40) @(posedge mclk);
      rd_reg(8'h20);
      ext_val <= 5'h01;
      repeat (40) @(posedge mclk);
      rd_reg(8'h20);
      chk(r[2:0], 3'b101);
      rd_reg(8'h20);
      chk(r[2:0], 3'b001);
      ext_val <= 5'h00;
      repeat (40) @(posedge mclk);
      ext_val <= 5'h01;
      repeat (40) @(posedge mclk);
      rd_reg(8'h20);
      chk(r[2:0], 3'b111);
      ce <= 1'b0;
      wr_reg(8'h00, 32'h121);
      ce <= 1'b1;
      rd_reg(8'h00);
      chk(r, 32'h322);
      $display("pin input test done");
      print_verdict;
   end
endmodule
